// *** design/wcsm_top.sv ***
// Behaviour
// - Buffer phase two/four clocks; derive phase-one and phase-two-three strobes.
// - Phase-one strobe enables driving stored bits 17..0 to the processor.
// - Store is 1024 x 24 from 1-bit slices; page from mux and paging.
// - Bus reads return one of three registers through a read-back mux.
// - Decode register window but never answer address 177546.
// - Receive microaddress 10..0 and disable line 16; drive 22 word bits.
// - Drive only when in range, store enabled, no disable in previous phase 3.
// - Trace buffer 16 deep, addressed by one 4-bit counter.
// - Each trace entry records the 11-bit mux microaddress.
// - Entry bit 11 records whether the store answered; entries bus readable.
// - Word bits 22 and 23 go out as extended control outputs.
// - Decode the 4-bit standard control code into its strobes.
// - Running trace counter advances every microcycle modulo 16.
// - Word with bit 23 set freezes trace, its own address kept.
// - Store disabled: no micro bus answer; bus may read and write it.
`timescale 1ns/1ps
module wcsm_top #(
   parameter logic [1:0] RANGE_SEL = 2'h1
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_phase_two_clock,
   input wire logic i_phase_four_clock,
   input wire logic [wcsm_pkg::ADDR_W-1:0] i_micro_bus_addr,
   input wire logic i_micro_bus_disable,
   input wire logic i_page_mode2,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [15:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   output logic [15:0] o_reg_rdata,
   output logic o_reg_ack,
   output logic o_phase_one_strobe,
   output logic o_phase_two_three_strobe,
   output logic [wcsm_pkg::OUT_W-1:0] o_micro_bus_data,
   output logic [wcsm_pkg::OUT_W-1:0] o_micro_bus_oe,
   output logic [1:0] o_ext_ctl,
   output wcsm_pkg::wcsm_ctl_t o_ctl
);
   function automatic wcsm_pkg::wcsm_ctl_t decode_code(input logic [3:0] c);
      wcsm_pkg::wcsm_ctl_t d;
      d = '0;
      d.intr_flag_clear_run = (c == wcsm_pkg::CODE_IFCLR_RUN);
      d.trace_flag_clear = (c == wcsm_pkg::CODE_TFCLR);
      d.flag_set_strobe = (c == wcsm_pkg::CODE_FSET);
      d.init_set = (c == wcsm_pkg::CODE_INIT);
      d.fast_data_in = (c == wcsm_pkg::CODE_FDIN);
      d.powerfail_flag_clear = (c == wcsm_pkg::CODE_PFCLR);
      d.event_flag_clear = (c == wcsm_pkg::CODE_EFCLR);
      return d;
   endfunction : decode_code

   // Link inputs come from the processor clock world
   logic [1:0] ph2_sync_reg, ph4_sync_reg, dis_sync_reg;
   logic [wcsm_pkg::ADDR_W-1:0] adr_meta_reg, adr_sync_reg;
   logic ph2_last_reg, ph4_last_reg;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ph2_sync_reg <= 2'h0;
         ph4_sync_reg <= 2'h0;
         dis_sync_reg <= 2'h0;
         adr_meta_reg <= '0;
         adr_sync_reg <= '0;
         ph2_last_reg <= 1'b0;
         ph4_last_reg <= 1'b0;
      end else begin
         ph2_sync_reg <= {ph2_sync_reg[0], i_phase_two_clock};
         ph4_sync_reg <= {ph4_sync_reg[0], i_phase_four_clock};
         dis_sync_reg <= {dis_sync_reg[0], i_micro_bus_disable};
         adr_meta_reg <= i_micro_bus_addr;
         adr_sync_reg <= adr_meta_reg;
         ph2_last_reg <= ph2_sync_reg[1];
         ph4_last_reg <= ph4_sync_reg[1];
      end
   end
   logic ph2_rise, ph2_fall, ph4_rise, ph4_fall;
   assign ph2_rise = ph2_sync_reg[1] & ~ph2_last_reg;
   assign ph2_fall = ~ph2_sync_reg[1] & ph2_last_reg;
   assign ph4_rise = ph4_sync_reg[1] & ~ph4_last_reg;
   assign ph4_fall = ~ph4_sync_reg[1] & ph4_last_reg;

   wcsm_pkg::wcsm_phase_t phase_reg, phase_next;
   always_comb begin
      case (phase_reg)
         wcsm_pkg::PH_ONE: phase_next = ph2_rise ? wcsm_pkg::PH_TWO : wcsm_pkg::PH_ONE;
         wcsm_pkg::PH_TWO: phase_next = ph2_fall ? wcsm_pkg::PH_THREE : wcsm_pkg::PH_TWO;
         wcsm_pkg::PH_THREE: phase_next = ph4_rise ? wcsm_pkg::PH_FOUR : wcsm_pkg::PH_THREE;
         wcsm_pkg::PH_FOUR: phase_next = ph4_fall ? wcsm_pkg::PH_ONE : wcsm_pkg::PH_FOUR;
         default: phase_next = wcsm_pkg::PH_ONE;
      endcase
   end
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) phase_reg <= wcsm_pkg::PH_ONE;
      else phase_reg <= phase_next;
   end

   logic [15:0] csr_reg;
   logic page_reg, fetch_en_reg, dis_prev_reg, frozen_reg;
   logic [wcsm_pkg::WORD_W-1:0] word_reg;
   logic [wcsm_pkg::ADDR_W-1:0] last_adr_reg;
   logic [wcsm_pkg::CNT_W-1:0] cnt_reg;
   wcsm_pkg::wcsm_trace_t trace_mem [2**wcsm_pkg::CNT_W];

   logic [wcsm_pkg::ADDR_W-1:0] mux_microaddress;
   logic [wcsm_pkg::IDX_W-1:0] store_idx;
   logic in_range, fetch_en_next;
   assign in_range = (adr_sync_reg[10:9] == RANGE_SEL);
   assign mux_microaddress = csr_reg[wcsm_pkg::CSR_EN] ? adr_sync_reg
                           : {1'b0, csr_reg[wcsm_pkg::IDX_W-1:0]};
   assign store_idx = csr_reg[wcsm_pkg::CSR_EN]
                    ? {page_reg, mux_microaddress[wcsm_pkg::PAGE_BIT-1:0]}
                    : mux_microaddress[wcsm_pkg::IDX_W-1:0];
   assign fetch_en_next = in_range & csr_reg[wcsm_pkg::CSR_EN] & ~dis_prev_reg;

   // disable line seen in phase 3 blocks the next cycle
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) dis_prev_reg <= 1'b0;
      else if (phase_reg == wcsm_pkg::PH_THREE && ph4_rise) dis_prev_reg <= dis_sync_reg[1];
   end

   // Bus decode; 177546 belongs to another option
   logic hit_csr, hit_low, hit_high, bus_wr_low, bus_wr_high;
   assign hit_csr = (i_reg_addr == wcsm_pkg::ADR_CSR);
   assign hit_low = (i_reg_addr == wcsm_pkg::ADR_LOW);
   assign hit_high = (i_reg_addr == wcsm_pkg::ADR_HIGH);
   assign bus_wr_low = i_reg_wr & hit_low & ~csr_reg[wcsm_pkg::CSR_EN]
                     & ~csr_reg[wcsm_pkg::CSR_EXAM];
   assign bus_wr_high = i_reg_wr & hit_high & ~csr_reg[wcsm_pkg::CSR_EN];

   logic [wcsm_pkg::WORD_W-1:0] ram_q;
   genvar b;
   generate
      for (b = 0; b < wcsm_pkg::WORD_W; b++) begin : g_slice
         logic slice_mem [wcsm_pkg::DEPTH];
         logic wr_bit;
         assign wr_bit = (b < 16) ? bus_wr_low : bus_wr_high;
         always_ff @(posedge i_clk) begin
            if (wr_bit) slice_mem[store_idx] <= i_reg_wdata[b % 16];
         end
         assign ram_q[b] = slice_mem[store_idx];
      end
   endgenerate

   // Fetch at microaccess time
   logic fetch_ev, trace_run;
   assign fetch_ev = ph2_rise;
   assign trace_run = ~csr_reg[wcsm_pkg::CSR_RESET] & ~frozen_reg;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         word_reg <= '0;
         fetch_en_reg <= 1'b0;
         last_adr_reg <= '0;
      end else if (fetch_ev) begin
         word_reg <= ram_q;
         fetch_en_reg <= fetch_en_next;
         last_adr_reg <= adr_sync_reg;
      end
   end

   // Paging logic; swap taken at the end of phase 3
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) page_reg <= 1'b0;
      else if (csr_reg[wcsm_pkg::CSR_RESET]) page_reg <= 1'b0;
      // page swap only in mode 2
      else if (ph4_rise && fetch_en_reg && i_page_mode2
               && word_reg[21:18] == wcsm_pkg::CODE_PAGE_SWAP) page_reg <= ~page_reg;
   end

   // Trace counter, freeze and examine stepping
   logic tog_step;
   assign tog_step = i_reg_wr & hit_csr & csr_reg[wcsm_pkg::CSR_EXAM]
                   & i_reg_wdata[wcsm_pkg::CSR_EXAM]
                   & (i_reg_wdata[wcsm_pkg::CSR_TOG] != csr_reg[wcsm_pkg::CSR_TOG]);
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_reg <= '0;
         frozen_reg <= 1'b0;
      end else if (csr_reg[wcsm_pkg::CSR_RESET]) begin
         cnt_reg <= '0;
         frozen_reg <= 1'b0;
      end else begin
         if (fetch_ev && trace_run) cnt_reg <= cnt_reg + 4'h1;
         else if (tog_step) cnt_reg <= cnt_reg - 4'h1;
         // freeze after the stop word's own entry
         if (ph2_fall && fetch_en_reg && word_reg[wcsm_pkg::STOP_BIT]) frozen_reg <= 1'b1;
      end
   end
   always_ff @(posedge i_clk) begin
      if (fetch_ev && trace_run) trace_mem[cnt_reg] <= '{en: fetch_en_next, addr: mux_microaddress};
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) csr_reg <= '0;
      else if (i_reg_wr && hit_csr) csr_reg <= i_reg_wdata & wcsm_pkg::CSR_WMASK;
   end

   logic [15:0] rd_mux;
   wcsm_pkg::wcsm_trace_t tword;
   assign tword = trace_mem[cnt_reg];
   always_comb begin
      rd_mux = '0;
      if (hit_csr) begin
         rd_mux = csr_reg;
         if (csr_reg[wcsm_pkg::CSR_EN]) rd_mux[wcsm_pkg::IDX_W-1:0] = last_adr_reg[wcsm_pkg::IDX_W-1:0];
      end else if (hit_low && csr_reg[wcsm_pkg::CSR_EXAM])
         rd_mux = {cnt_reg, tword};
      else if (hit_low)
         rd_mux = csr_reg[wcsm_pkg::CSR_EN] ? word_reg[15:0] : ram_q[15:0];
      else if (hit_high)
         rd_mux = {8'h00, csr_reg[wcsm_pkg::CSR_EN] ? word_reg[23:16] : ram_q[23:16]};
   end
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_reg_rdata <= '0;
         o_reg_ack <= 1'b0;
      end else begin
         o_reg_ack <= (i_reg_rd | i_reg_wr) & (hit_csr | hit_low | hit_high);
         o_reg_rdata <= i_reg_rd ? rd_mux : 16'h0000;
      end
   end

   // Micro bus drive, strobes and control outputs
   logic p1_n, p23_n, en_n;
   assign p1_n = (phase_next == wcsm_pkg::PH_ONE);
   assign p23_n = (phase_next == wcsm_pkg::PH_TWO) | (phase_next == wcsm_pkg::PH_THREE);
   // clearing enable drops drive at once
   assign en_n = (fetch_ev ? fetch_en_next : fetch_en_reg) & csr_reg[wcsm_pkg::CSR_EN];
   logic [wcsm_pkg::WORD_W-1:0] word_n;
   assign word_n = fetch_ev ? ram_q : word_reg;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_phase_one_strobe <= 1'b1;
         o_phase_two_three_strobe <= 1'b0;
         o_micro_bus_data <= '0;
         o_micro_bus_oe <= '0;
         o_ext_ctl <= 2'h0;
         o_ctl <= '0;
      end else begin
         o_phase_one_strobe <= p1_n;
         o_phase_two_three_strobe <= p23_n;
         o_micro_bus_data <= word_n[wcsm_pkg::OUT_W-1:0];
         o_micro_bus_oe[wcsm_pkg::DRV_HI:0] <= {(wcsm_pkg::DRV_HI+1){p1_n & en_n}};
         // control code gated by phases 2 and 3
         o_micro_bus_oe[wcsm_pkg::OUT_W-1:wcsm_pkg::CODE_LO] <= {4{p23_n & en_n}};
         o_ext_ctl <= en_n ? word_n[wcsm_pkg::STOP_BIT:wcsm_pkg::EXT_LO] : 2'h0;
         // strobes during phases 2 and 3
         o_ctl <= (p23_n & en_n) ? decode_code(word_n[21:18]) : '0;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   property p_strobe_excl; !(o_phase_one_strobe && o_phase_two_three_strobe); endproperty
   a_strobe_excl: assert property (p_strobe_excl) else $error("phase strobes overlap");
   property p_low_drive; o_micro_bus_oe[0] |-> o_phase_one_strobe; endproperty
   a_low_drive: assert property (p_low_drive) else $error("low field driven off phase one");
   property p_drive_en; o_micro_bus_oe[0] |-> $past(csr_reg[wcsm_pkg::CSR_EN]) && fetch_en_reg;
   endproperty
   a_drive_en: assert property (p_drive_en) else $error("drive without enable");
   property p_foreign; (i_reg_rd || i_reg_wr) && i_reg_addr == wcsm_pkg::ADR_FOREIGN |=> !o_reg_ack;
   endproperty
   a_foreign: assert property (p_foreign) else $error("answered foreign address");
   property p_csr_read; i_reg_rd && hit_csr && !csr_reg[wcsm_pkg::CSR_EN] && !i_reg_wr
      |=> o_reg_ack && o_reg_rdata == $past(csr_reg); endproperty
   a_csr_read: assert property (p_csr_read) else $error("bad control word readback");
   property p_advance; fetch_ev && trace_run |=> cnt_reg == $past(cnt_reg) + 4'h1; endproperty
   a_advance: assert property (p_advance) else $error("trace counter did not advance");
   property p_frozen; frozen_reg && !csr_reg[wcsm_pkg::CSR_RESET] && !i_reg_wr |=> $stable(cnt_reg);
   endproperty
   a_frozen: assert property (p_frozen) else $error("frozen trace moved");
   property p_off; !csr_reg[wcsm_pkg::CSR_EN] |=> o_micro_bus_oe == '0; endproperty
   a_off: assert property (p_off) else $error("disabled store drove bus");
   property p_code; o_ctl != '0 |-> o_phase_two_three_strobe; endproperty
   a_code: assert property (p_code) else $error("control strobe outside phases 2 and 3");
   c_drive: cover property (o_micro_bus_oe[0] ##[1:20] o_ctl.trace_flag_clear);
   c_freeze: cover property ($rose(frozen_reg));
   c_trace_read: cover property (i_reg_rd && hit_low && csr_reg[wcsm_pkg::CSR_EXAM]);
endmodule : wcsm_top

// *** design/wcsm_pkg.sv ***
package wcsm_pkg;
   localparam int ADDR_W = 11;
   localparam int IDX_W = 10;
   localparam int WORD_W = 24;
   localparam int DEPTH = 1024;
   localparam int CNT_W = 4;
   localparam int OUT_W = 22;
   localparam int DRV_HI = 17;
   localparam int CODE_LO = 18;
   localparam int EXT_LO = 22;
   localparam int STOP_BIT = 23;
   localparam int PAGE_BIT = 9;
   localparam int DIS_BIT = 16;
   // Register window, system bus byte addresses
   localparam logic [15:0] ADR_CSR = 16'hFF60;
   localparam logic [15:0] ADR_LOW = 16'hFF62;
   localparam logic [15:0] ADR_HIGH = 16'hFF64;
   localparam logic [15:0] ADR_FOREIGN = 16'hFF66;
   localparam int CSR_RESET = 15;
   localparam int CSR_EXAM = 14;
   localparam int CSR_TOG = 13;
   localparam int CSR_EN = 12;
   localparam logic [15:0] CSR_WMASK = 16'hF3FF;
   localparam logic [3:0] CODE_PAGE_SWAP = 4'h7;
   localparam logic [3:0] CODE_IFCLR_RUN = 4'h9;
   localparam logic [3:0] CODE_TFCLR = 4'hA;
   localparam logic [3:0] CODE_FSET = 4'hB;
   localparam logic [3:0] CODE_INIT = 4'hC;
   localparam logic [3:0] CODE_FDIN = 4'hD;
   localparam logic [3:0] CODE_PFCLR = 4'hE;
   localparam logic [3:0] CODE_EFCLR = 4'hF;
   typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} wcsm_phase_t;
   typedef struct packed {
      logic intr_flag_clear_run;
      logic trace_flag_clear;
      logic flag_set_strobe;
      logic init_set;
      logic fast_data_in;
      logic powerfail_flag_clear;
      logic event_flag_clear;
   } wcsm_ctl_t;
   typedef struct packed {
      logic en;
      logic [ADDR_W-1:0] addr;
   } wcsm_trace_t;
endpackage : wcsm_pkg

// *** tb/wcsm_cpu_model.sv ***
`timescale 1ns/1ps
module wcsm_cpu_model (
   output logic o_phase_two_clock,
   output logic o_phase_four_clock,
   output logic [10:0] o_addr,
   output logic o_disable
);
   initial begin
      o_phase_two_clock = 1'b0;
      o_phase_four_clock = 1'b0;
      o_addr = 11'h000;
      o_disable = 1'b0;
   end
   // Phases run 1,2,3,4; clocks stand still between calls
   task automatic fetch(input logic [10:0] a, input logic d, input logic slow);
      int t;
      t = slow ? 80 : 40;
      o_addr = a;
      #(t);
      o_phase_two_clock = 1'b1;
      #(t);
      o_phase_two_clock = 1'b0;
      o_disable = d;
      #(t);
      o_phase_four_clock = 1'b1;
      #(t);
      o_phase_four_clock = 1'b0;
   endtask : fetch
endmodule : wcsm_cpu_model

// *** tb/wcsm_top_test.sv ***
`timescale 1ns/1ps
module wcsm_top_test;
   logic i_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic i_reg_wr = 1'b0;
   logic i_reg_rd = 1'b0;
   logic [15:0] i_reg_addr = 16'h0000;
   logic [15:0] i_reg_wdata = 16'h0000;
   logic i_page_mode2 = 1'b0;
   logic ph2, ph4, dis, o_reg_ack, o_phase_one_strobe, o_phase_two_three_strobe;
   logic [10:0] maddr;
   logic [15:0] o_reg_rdata;
   logic [wcsm_pkg::OUT_W-1:0] o_micro_bus_data, o_micro_bus_oe;
   logic [1:0] o_ext_ctl, rng;
   wcsm_pkg::wcsm_ctl_t o_ctl;
   int error_cnt = 0;
   int n_compared = 0;
   int i, j, k, idx;
   logic [16:0] rq[$];
   logic [24:0] fq[$];
   logic [16:0] rn;
   logic [24:0] cur = 25'h0;
   logic [23:0] w[16];
   logic [23:0] wp;
   logic [11:0] tr[16];
   logic [3:0] tp, c;
   logic p1_q = 1'b1;
   logic p23_q = 1'b0;
   logic d, dprev, en;

   always #10 i_clk = ~i_clk;

   wcsm_cpu_model u_cpu (.o_phase_two_clock(ph2), .o_phase_four_clock(ph4),
      .o_addr(maddr), .o_disable(dis));

   wcsm_top #(.RANGE_SEL(2'h1)) DUT (.i_clk(i_clk), .i_arst_n(i_arst_n),
      .i_phase_two_clock(ph2), .i_phase_four_clock(ph4), .i_micro_bus_addr(maddr),
      .i_micro_bus_disable(dis), .i_page_mode2(i_page_mode2), .i_reg_wr(i_reg_wr),
      .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
      .o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack),
      .o_phase_one_strobe(o_phase_one_strobe),
      .o_phase_two_three_strobe(o_phase_two_three_strobe),
      .o_micro_bus_data(o_micro_bus_data), .o_micro_bus_oe(o_micro_bus_oe),
      .o_ext_ctl(o_ext_ctl), .o_ctl(o_ctl));

   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   function automatic logic [6:0] ctl_of(input logic e, input logic [3:0] code);
      ctl_of = (e && code >= 4'h9) ? 7'(7'h01 << (4'hF - code)) : 7'h00;
   endfunction : ctl_of

   // Reads carry expected data; unmapped requests push nothing
   task automatic bus(input logic wr, input logic [15:0] a, input logic [15:0] v,
         input logic mapped);
      @(posedge i_clk);
      if (mapped) rq.push_back({~wr, v});
      i_reg_wr <= wr;
      i_reg_rd <= ~wr;
      i_reg_addr <= a;
      i_reg_wdata <= wr ? v : 16'h0000;
      @(posedge i_clk);
      i_reg_wr <= 1'b0;
      i_reg_rd <= 1'b0;
   endtask : bus

   task automatic mfetch(input logic [10:0] a, input logic dd, input logic e);
      fq.push_back({e, w[a[3:0]]});
      tr[tp] = {e, a};
      tp = tp + 4'h1;
      u_cpu.fetch(a, dd, $urandom_range(2, 0) == 0);
   endtask : mfetch

   task automatic final_report;
      if (rq.size() != 0 || fq.size() != 0) begin
         error_cnt++;
         $display("BAD %0t expected results never seen", $time);
      end
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : final_report

   always @(posedge i_clk) begin
      p1_q <= o_phase_one_strobe;
      p23_q <= o_phase_two_three_strobe;
      if (o_reg_ack === 1'b1) begin
         if (rq.size() == 0) begin
            error_cnt++;
            $display("BAD %0t ack without request", $time);
         end else begin
            rn = rq.pop_front();
            if (rn[16]) chk(24'(o_reg_rdata), 24'(rn[15:0]), "read data");
         end
      end
      if (o_phase_two_three_strobe === 1'b1 && p23_q === 1'b0) begin
         if (fq.size() == 0) chk(24'h1, 24'h0, "fetch without note");
         else cur = fq.pop_front();
         chk({o_ext_ctl, o_micro_bus_oe[21:18], 11'h0, o_ctl}, {cur[24] ? cur[23:22] : 2'h0,
            {4{cur[24]}}, 11'h0, ctl_of(cur[24], cur[21:18])}, "phase 2/3 outputs");
         if (cur[24]) chk(24'(o_micro_bus_data), 24'(cur[21:0]), "word");
      end
      if (o_phase_one_strobe === 1'b1 && p1_q === 1'b0)
         chk(24'(o_micro_bus_oe[17:0]), 24'({18{cur[24]}}), "phase 1 enables");
   end

   initial begin
      void'($urandom(32'hC917));
      repeat (3) @(posedge i_clk);
      i_arst_n <= 1'b1;
      @(negedge i_clk);
      chk(24'({o_phase_one_strobe, o_phase_two_three_strobe, o_ext_ctl, o_ctl}),
         24'h000400, "reset outputs");
      for (i = 0; i < 16; i++) begin
         w[i] = {i == 15, 1'($urandom), 4'(i), 18'($urandom)};
         bus(1'b1, wcsm_pkg::ADR_CSR, 16'(i), 1'b1);
         bus(1'b1, wcsm_pkg::ADR_LOW, w[i][15:0], 1'b1);
         bus(1'b1, wcsm_pkg::ADR_HIGH, {8'h00, w[i][23:16]}, 1'b1);
         bus(1'b0, wcsm_pkg::ADR_CSR, 16'(i), 1'b1);
         bus(1'b0, wcsm_pkg::ADR_LOW, w[i][15:0], 1'b1);
         bus(1'b0, wcsm_pkg::ADR_HIGH, {8'h00, w[i][23:16]}, 1'b1);
      end
      // Page one copy of word 7 for the swap scenario
      wp = {1'b0, 1'($urandom), 4'h3, 18'($urandom)};
      bus(1'b1, wcsm_pkg::ADR_CSR, 16'h0207, 1'b1);
      bus(1'b1, wcsm_pkg::ADR_LOW, wp[15:0], 1'b1);
      bus(1'b1, wcsm_pkg::ADR_HIGH, {8'h00, wp[23:16]}, 1'b1);
      bus(1'b0, wcsm_pkg::ADR_FOREIGN, 16'h0000, 1'b0);
      tp = 4'h0;
      #7;
      // Store still disabled: no answer
      mfetch(11'h201, 1'b0, 1'b0);
      bus(1'b1, wcsm_pkg::ADR_CSR, 16'h8000, 1'b1);
      bus(1'b1, wcsm_pkg::ADR_CSR, 16'h1000, 1'b1);
      tp = 4'h0;
      dprev = 1'b0;
      for (k = 0; k < 20; k++) begin
         idx = (k < 15) ? k : $urandom_range(14, 0);
         rng = (k >= 15 && $urandom_range(1, 0) == 1) ? 2'h2 : 2'h1;
         d = (k >= 15 && k < 19) ? 1'($urandom) : 1'b0;
         en = (rng == 2'h1) && !dprev;
         mfetch({rng, 9'(idx)}, d, en);
         dprev = d;
      end
      mfetch(11'h20F, 1'b0, 1'b1);
      repeat (8) @(posedge i_clk);
      bus(1'b1, wcsm_pkg::ADR_CSR, 16'h5000, 1'b1);
      // Each toggle of bit 13 steps the counter down, wrapping
      for (j = 0; j < 16; j++) begin
         if (j > 0) bus(1'b1, wcsm_pkg::ADR_CSR, j[0] ? 16'h7000 : 16'h5000, 1'b1);
         c = 4'(5 - j);
         bus(1'b0, wcsm_pkg::ADR_LOW, {c, tr[c]}, 1'b1);
      end
      // Swap code only honoured in mode 2; next fetch reads page one
      i_page_mode2 <= 1'b1;
      bus(1'b1, wcsm_pkg::ADR_CSR, 16'h8000, 1'b1);
      bus(1'b1, wcsm_pkg::ADR_CSR, 16'h1000, 1'b1);
      mfetch(11'h207, 1'b0, 1'b1);
      fq.push_back({1'b1, wp});
      u_cpu.fetch(11'h207, 1'b0, 1'b0);
      repeat (4) @(posedge i_clk);
      final_report;
   end

   initial begin
      #200000;
      error_cnt++;
      $display("BAD %0t watchdog expired", $time);
      final_report;
   end
endmodule : wcsm_top_test
